// >>> asr_host.sv
// Host controller for an asynchronous 2M x 16 static memory
// Overview of operation
// - Write: selects active, strobe low, lanes gated
// - Read: selects active, output enable low, strobe high
// - Address held 40 ns before write end
// - Lane 40 ns, data 25 ns before end
// - Wait 55 ns after retention before use
`timescale 1ns/1ps
module asr_host (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // User request port
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [asr_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [asr_pkg::DATA_W-1:0] REQ_WDATA,
    input wire logic [asr_pkg::LANE_W-1:0] REQ_LANES,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [asr_pkg::DATA_W-1:0] RSP_RDATA,
    // Retention control
    input wire logic RETAIN_EXIT,
    // Memory pins
    output logic [asr_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic MEM_CHIP_SEL_N,
    output logic MEM_CHIP_SEL,
    output logic MEM_OUT_EN_N,
    output logic MEM_WRITE_N,
    output logic MEM_LOWER_BYTE_SEL_N,
    output logic MEM_UPPER_BYTE_SEL_N,
    input wire logic [asr_pkg::DATA_W-1:0] MEM_DATA_IN,
    output logic [asr_pkg::DATA_W-1:0] MEM_DATA_OUT,
    output logic MEM_DATA_OE
);
    import asr_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    asr_timer_if tmr ();                         // Phase timer link
    asr_state_type state, next_state;            // Access sequencer
    logic [DATA_W-1:0] din_meta, din_sync;       // Two-stage capture of pin data
    logic [DATA_W-1:0] next_rdata;
    logic next_rsp_valid, next_ready;
    logic [ADDR_W-1:0] next_addr;
    logic next_cs, next_oe_n, next_we_n, next_data_oe;
    logic [LANE_W-1:0] next_lanes_n, lanes_n;    // Byte selects, low active
    logic [DATA_W-1:0] next_dout;
    logic retain_meta, retain_sync;              // Retention exit request, synced
    logic [CNT_W-1:0] next_count;
    logic next_load;
    logic cs;                                    // Chip selected

    // Lane mask from active-low selects, used for read data only
    function automatic logic [DATA_W-1:0] lane_mask(input logic [LANE_W-1:0] sel_n);
        lane_mask = {{8{~sel_n[1]}}, {8{~sel_n[0]}}};
    endfunction

    asr_timer u_timer (
        .REF_CLK(REF_CLK),
        .RST_N(RST_N),
        .tmr(tmr.timer)
    );
    assign tmr.load = next_load;
    assign tmr.count = next_count;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Data pins come from a clockless part, so two stages before use
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
            retain_meta <= 1'b0;
            retain_sync <= 1'b0;
        end else begin
            din_meta <= MEM_DATA_IN;
            din_sync <= din_meta;
            retain_meta <= RETAIN_EXIT;
            retain_sync <= retain_meta;
        end
    end

    // ----------------------------------------
    // Sequencer next values
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rdata = RSP_RDATA;
        next_addr = MEM_ADDR;
        next_cs = cs;
        next_oe_n = MEM_OUT_EN_N;
        next_we_n = MEM_WRITE_N;
        next_lanes_n = lanes_n;
        next_dout = MEM_DATA_OUT;
        next_data_oe = MEM_DATA_OE;
        next_load = 1'b0;
        next_count = 4'h0;
        case (state)
            // Wait out recovery after retention before any access; after reset the count is zero, so no wait
            ASR_RECOVER: begin
                if (tmr.done) begin
                    next_state = ASR_IDLE;
                    next_ready = 1'b1;
                end
            end
            ASR_IDLE: begin
                next_ready = 1'b1;
                if (retain_sync) begin
                    // Retention exit: restart the recovery wait
                    next_ready = 1'b0;
                    next_load = 1'b1;
                    next_count = CNT_W'(RECOVER_CYC);
                    next_state = ASR_RECOVER;
                end else if (REQ_VALID && REQ_LANES != 2'h0) begin
                    // Address and lanes set with select, so setup is met at start
                    next_ready = 1'b0;
                    next_addr = REQ_ADDR;
                    next_cs = 1'b1;
                    next_lanes_n = ~REQ_LANES;
                    next_load = 1'b1;
                    if (REQ_WRITE) begin
                        // Strobe low with output enable high keeps the bus clean
                        next_oe_n = 1'b1;
                        next_we_n = 1'b0;
                        next_dout = REQ_WDATA;
                        next_count = CNT_W'(WR_PULSE_CYC);
                        next_state = ASR_WRITE;
                    end else begin
                        next_oe_n = 1'b0;
                        next_we_n = 1'b1;
                        next_count = CNT_W'(RD_CYC);
                        next_state = ASR_READ;
                    end
                end
            end
            ASR_READ: begin
                if (tmr.done) begin
                    // Only the selected lanes carry data; others read as zero
                    next_rdata = din_sync & lane_mask(lanes_n);
                    next_rsp_valid = 1'b1;
                    next_cs = 1'b0;
                    next_oe_n = 1'b1;
                    next_lanes_n = 2'h3;
                    next_ready = 1'b1;
                    next_state = ASR_IDLE;
                end
            end
            ASR_WRITE: begin
                // Drive data only once the memory outputs have floated
                if (tmr.done) begin
                    // Strobe rises first: whole overlap closes on this edge
                    next_we_n = 1'b1;
                    next_load = 1'b1;
                    next_count = CNT_W'(WR_CYC - WR_PULSE_CYC);
                    next_state = ASR_WR_TAIL;
                end else begin
                    next_data_oe = 1'b1;
                end
            end
            ASR_WR_TAIL: begin
                // Release data with the strobe high so the hold of zero is met
                next_data_oe = 1'b0;
                next_cs = 1'b0;
                next_lanes_n = 2'h3;
                if (tmr.done) begin
                    next_ready = 1'b1;
                    next_state = ASR_IDLE;
                end
            end
            default: begin
                next_state = ASR_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ASR_RECOVER;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 16'h0000;
            MEM_ADDR <= 21'h000000;
            cs <= 1'b0;
            MEM_OUT_EN_N <= 1'b1;
            MEM_WRITE_N <= 1'b1;
            lanes_n <= 2'h3;
            MEM_DATA_OUT <= 16'h0000;
            MEM_DATA_OE <= 1'b0;
            MEM_CHIP_SEL_N <= 1'b1;
            MEM_CHIP_SEL <= 1'b0;
            MEM_LOWER_BYTE_SEL_N <= 1'b1;
            MEM_UPPER_BYTE_SEL_N <= 1'b1;
        end else begin
            state <= next_state;
            REQ_READY <= next_ready;
            RSP_VALID <= next_rsp_valid;
            RSP_RDATA <= next_rdata;
            MEM_ADDR <= next_addr;
            cs <= next_cs;
            MEM_OUT_EN_N <= next_oe_n;
            MEM_WRITE_N <= next_we_n;
            lanes_n <= next_lanes_n;
            MEM_DATA_OUT <= next_dout;
            MEM_DATA_OE <= next_data_oe;
            MEM_CHIP_SEL_N <= ~next_cs;
            MEM_CHIP_SEL <= next_cs;
            MEM_LOWER_BYTE_SEL_N <= next_lanes_n[0];
            MEM_UPPER_BYTE_SEL_N <= next_lanes_n[1];
        end
    end
endmodule // asr_host

// >>> asr_host_properties.sv
// Checker of the memory pin timing of the asynchronous SRAM host controller
`timescale 1ns/1ps
module asr_host_properties (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // User port
    input wire logic [asr_pkg::LANE_W-1:0] REQ_LANES,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    // Memory pins
    input wire logic [asr_pkg::ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_CHIP_SEL_N,
    input wire logic MEM_CHIP_SEL,
    input wire logic MEM_OUT_EN_N,
    input wire logic MEM_WRITE_N,
    input wire logic MEM_LOWER_BYTE_SEL_N,
    input wire logic MEM_UPPER_BYTE_SEL_N,
    input wire logic [asr_pkg::DATA_W-1:0] MEM_DATA_OUT,
    input wire logic MEM_DATA_OE
);
    // ----------------------------------------
    // One domain, so one clock and reset
    // ----------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Host never fights the memory for the bus
    bus_excl_a: assert property (MEM_DATA_OE |-> MEM_OUT_EN_N)
        else $error("host drives bus while memory outputs enabled");
    // Strobe stays high across a read
    read_we_high_a: assert property (!MEM_OUT_EN_N |-> MEM_WRITE_N)
        else $error("write strobe low during read");
    // 40 ns strobe is five whole cycles
    we_width_a: assert property ($fell(MEM_WRITE_N) |-> !MEM_WRITE_N [*5])
        else $error("write strobe pulse too short");
    // Address and data frozen while the write window is open
    wr_stable_a: assert property (!MEM_WRITE_N |=> $stable(MEM_ADDR) && $stable(MEM_DATA_OUT))
        else $error("address or data moved during write");
    // Data driven 32 ns and select 40 ns before write end
    wr_setup_a: assert property ($rose(MEM_WRITE_N) |->
        $past(MEM_DATA_OE, 4) && $past(MEM_CHIP_SEL, 5))
        else $error("setup before write end too short");
    // Byte selects follow the requested lanes
    lane_map_a: assert property (($fell(MEM_OUT_EN_N) || $fell(MEM_WRITE_N)) |->
        {MEM_UPPER_BYTE_SEL_N, MEM_LOWER_BYTE_SEL_N} == ~$past(REQ_LANES))
        else $error("byte selects differ from request lanes");
    // Response after the full 55 ns access plus synchroniser
    read_time_a: assert property ($fell(MEM_OUT_EN_N) |-> ##9 RSP_VALID)
        else $error("read response not on time");
    // Idle controller keeps the memory deselected
    idle_desel_a: assert property (REQ_READY |-> MEM_CHIP_SEL_N && !MEM_CHIP_SEL
        && MEM_WRITE_N && !MEM_DATA_OE)
        else $error("memory selected while idle");
endmodule // asr_host_properties

bind asr_host asr_host_properties chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .REQ_LANES(REQ_LANES), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .MEM_ADDR(MEM_ADDR), .MEM_CHIP_SEL_N(MEM_CHIP_SEL_N), .MEM_CHIP_SEL(MEM_CHIP_SEL),
    .MEM_OUT_EN_N(MEM_OUT_EN_N), .MEM_WRITE_N(MEM_WRITE_N),
    .MEM_LOWER_BYTE_SEL_N(MEM_LOWER_BYTE_SEL_N), .MEM_UPPER_BYTE_SEL_N(MEM_UPPER_BYTE_SEL_N),
    .MEM_DATA_OUT(MEM_DATA_OUT), .MEM_DATA_OE(MEM_DATA_OE));

// >>> asr_host_tb.sv
// Self-checking testbench of the asynchronous SRAM host controller
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module asr_host_tb;
    import asr_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, retain_exit = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_out, model_q, bus;
    logic [LANE_W-1:0] req_lanes = '0;
    logic req_ready, rsp_valid, cs_n, cs, oe_n, we_n, ls_n, us_n, data_oe;
    int err_total = 0, tests_run = 0, cycles = 0;
    assign bus = data_oe ? data_out : model_q; // Host wins only while it drives
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    asr_host uut (.REF_CLK(ref_clk), .RST_N(rst_n), .REQ_VALID(req_valid),
        .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .REQ_LANES(req_lanes), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata), .RETAIN_EXIT(retain_exit), .MEM_ADDR(mem_addr),
        .MEM_CHIP_SEL_N(cs_n), .MEM_CHIP_SEL(cs), .MEM_OUT_EN_N(oe_n), .MEM_WRITE_N(we_n),
        .MEM_LOWER_BYTE_SEL_N(ls_n), .MEM_UPPER_BYTE_SEL_N(us_n), .MEM_DATA_IN(bus),
        .MEM_DATA_OUT(data_out), .MEM_DATA_OE(data_oe));
    // Slow memory: data arrives near the end of the access window
    asr_sram_model #(.RD_DLY(50)) mem (.addr(mem_addr), .chip_sel_n(cs_n), .chip_sel(cs),
        .out_en_n(oe_n), .write_n(we_n), .lower_byte_sel_n(ls_n), .upper_byte_sel_n(us_n),
        .din(bus), .dq(model_q));
    // Verdict and end of run
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard well beyond the planned traffic
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    // One request, presented for one cycle once ready is seen
    task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [LANE_W-1:0] l);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin @(negedge ref_clk); n++; end
        {req_write, req_addr, req_wdata, req_lanes, req_valid} = {wr, a, d, l, 1'b1};
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask
    // Read and compare the returned word
    task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [LANE_W-1:0] l,
        input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        send(1'b0, a, 16'h0000, l);
        while (rsp_valid !== 1'b1 && n < 20) begin @(negedge ref_clk); n++; end
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_rdata, exp)
    endtask
    // Idle pins during reset leave memory deselected and floating
    task automatic t_reset();
        `CHK({cs_n, cs, oe_n, we_n, ls_n, us_n, data_oe}, 7'b1011110)
    endtask
    // Full words at both ends of the address range, back to back
    task automatic t_full();
        send(1'b1, 21'h1fffff, 16'hbeef, 2'h3);
        send(1'b1, 21'h000000, 16'h1234, 2'h3);
        read_chk(21'h1fffff, 2'h3, 16'hbeef);
        read_chk(21'h000000, 2'h3, 16'h1234);
    endtask
    // Single-lane writes keep the other byte; partial reads zero the rest
    task automatic t_lanes();
        send(1'b1, 21'h00abc, 16'haa55, 2'h3);
        send(1'b1, 21'h00abc, 16'h11ff, 2'h2);
        read_chk(21'h00abc, 2'h3, 16'h1155);
        send(1'b1, 21'h00abc, 16'h2277, 2'h1);
        read_chk(21'h00abc, 2'h1, 16'h0077);
        read_chk(21'h00abc, 2'h2, 16'h1100);
    endtask
    // A request with no lanes is never taken
    task automatic t_refuse();
        {req_write, req_lanes, req_valid} = {1'b1, 2'h0, 1'b1};
        repeat (4) @(negedge ref_clk);
        req_valid = 1'b0;
        `CHK({req_ready, cs_n, we_n}, 3'b111)
    endtask
    // Leaving retention holds off requests for the recovery time
    task automatic t_retain();
        int n;
        n = 0;
        retain_exit = 1'b1;
        while (req_ready !== 1'b0 && n < 8) begin @(negedge ref_clk); n++; end
        retain_exit = 1'b0;
        `CHK(req_ready, 1'b0)
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin @(negedge ref_clk); n++; end
        `CHK(n >= RECOVER_CYC, 1'b1)
        read_chk(21'h1fffff, 2'h3, 16'hbeef);
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        t_reset();
        rst_n = 1'b1;
        t_full();
        t_lanes();
        t_refuse();
        t_retain();
        give_verdict();
    end
endmodule // asr_host_tb

// >>> asr_pkg.sv
// Package of constants and types for the asynchronous SRAM host controller
package asr_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 21;                  // Word address lines 0..20
    localparam int DATA_W = 16;                  // Data bus width
    localparam int LANE_W = 2;                   // Byte lanes
    // ----------------------------------------
    // Timing in ns and clock rate
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;            // REF_CLK period
    localparam int T_READ_CYCLE_NS = 55;         // Least read cycle
    localparam int T_WRITE_CYCLE_NS = 55;        // Least write cycle
    localparam int T_ADDR_DATA_NS = 55;          // Address to data valid
    localparam int T_WE_PULSE_NS = 40;           // Least write strobe width
    localparam int T_DATA_SETUP_NS = 25;         // Data setup to write end
    localparam int T_WE_HIGHZ_NS = 20;           // Strobe low to outputs floating
    localparam int T_LOWZ_WE_NS = 10;            // Strobe high to outputs driving
    localparam int T_RECOVER_NS = 55;            // Recovery after retention
    // Least times round up to whole cycles; the read count takes one cycle more
    localparam int RD_CYC = (T_ADDR_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WR_PULSE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_HZ_CYC = (T_WE_HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (T_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;                    // Wide enough for all counts
    // ----------------------------------------
    // States
    // ----------------------------------------
    typedef enum logic [2:0] {
        ASR_RECOVER, ASR_IDLE, ASR_READ, ASR_WRITE, ASR_WR_TAIL
    } asr_state_type;
endpackage

// >>> asr_sram_model.sv
// Behavioural model of the 2M x 16 asynchronous static memory
`timescale 1ns/1ps
module asr_sram_model #(
    parameter int RD_DLY = 30
) (
    // Control pins
    input wire logic [asr_pkg::ADDR_W-1:0] addr,
    input wire logic chip_sel_n,
    input wire logic chip_sel,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic lower_byte_sel_n,
    input wire logic upper_byte_sel_n,
    // Data bus
    input wire logic [asr_pkg::DATA_W-1:0] din,
    output logic [asr_pkg::DATA_W-1:0] dq
);
    import asr_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]]; // Sparse 2M word array
    logic [DATA_W-1:0] word; // Stored word at address
    logic sel; // Selected and out of standby
    logic rd; // Read mode
    // Standby and power-down follow deselect at once in this model
    assign sel = !chip_sel_n && chip_sel && !(lower_byte_sel_n && upper_byte_sel_n);
    assign rd = sel && !out_en_n && write_n;
    initial dq = '0;
    // Read path: unselected lanes read the stored byte inverted; a floating bus inverts on each address, mode or lane change
    always @(addr, rd, lower_byte_sel_n, upper_byte_sel_n) begin
        word = mem.exists(addr) ? mem[addr] : 16'h5a5a;
        if (rd) begin
            dq <= #RD_DLY {upper_byte_sel_n ? ~word[15:8] : word[15:8],
                lower_byte_sel_n ? ~word[7:0] : word[7:0]};
        end else begin
            dq <= #RD_DLY ~dq;
        end
    end
    // Write lands when the strobe closes the window
    always @(posedge write_n) begin
        if (!chip_sel_n && chip_sel) begin
            if (!mem.exists(addr)) mem[addr] = 16'h5a5a;
            if (!lower_byte_sel_n) mem[addr][7:0] = din[7:0];
            if (!upper_byte_sel_n) mem[addr][15:8] = din[15:8];
        end
    end
endmodule // asr_sram_model

// >>> asr_timer.sv
// Down counter that times each phase of a memory access
`timescale 1ns/1ps
module asr_timer (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Control
    asr_timer_if.timer tmr
);
    import asr_pkg::*;
    logic [CNT_W-1:0] left;                      // Cycles remaining
    logic [CNT_W-1:0] next_left;
    // ----------------------------------------
    // Next count
    // ----------------------------------------
    always_comb begin
        next_left = left;
        if (tmr.load) begin
            next_left = tmr.count;               // Reload wins over decrement
        end else if (left != 4'h0) begin
            next_left = left - 4'h1;
        end
    end
    // ----------------------------------------
    // Register
    // ----------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            left <= 4'h0;
        end else begin
            left <= next_left;
        end
    end
    // Done looks only at the count: the sequencer reloads on done, so a
    // reload term here would close a combinational loop through it
    assign tmr.done = (left == 4'h0);
endmodule // asr_timer

// >>> asr_timer_if.sv
// Interface between the controller and its cycle timer
`timescale 1ns/1ps
interface asr_timer_if;
    logic load;                                  // Start a count
    logic [asr_pkg::CNT_W-1:0] count;            // Cycles to count
    logic done;                                  // Count has expired
    modport ctrl (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface // asr_timer_if
